//--- core/interrupt_priority_vector_map.sv
`timescale 1ns/1ps
module interrupt_priority_vector_map (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic [23:0]            req_set,
  input  wire logic [23:0]            req_clr,
  input  wire logic [47:0]            level_cfg,
  input  wire logic                   vector_base_wr,
  input  wire logic [20:0]            vector_base_in,
  input  wire logic                   fetch_ack,
  input  wire logic                   boot_map_select_wr,
  input  wire logic                   boot_map_select_in,
  input  wire logic                   flash_secured_state_wr,
  input  wire logic                   flash_secured_state_in,
  input  wire logic                   flash_secure_strap,
  input  wire logic                   watchdog_reset_flag,
  input  wire logic [20:0]            fetch_addr,
  output logic                        irq_valid_ff,
  output logic [4:0]                  irq_vector_ff,
  output logic [1:0]                  irq_level_ff,
  output logic [20:0]                 irq_fetch_addr_ff,
  output logic [23:0]                 pend_ff,
  output logic [20:0]                 vector_base_ff,
  output logic [20:0]                 reset_entry_ff,
  output logic                        boot_map_select_ff,
  output logic                        flash_secured_state_ff,
  output ivec_pkg::region_type        region_ff,
  output logic                        inaccessible_ff
);

  logic [23:0] nxt_pend;
  logic [47:0] eff_lvl;
  logic        nxt_valid;
  logic [4:0]  nxt_vector;
  logic [1:0]  nxt_level;
  logic [20:0] nxt_fetch_addr;
  logic [20:0] nxt_vector_base;
  logic [20:0] nxt_reset_entry;
  logic        nxt_map_sel;
  logic        nxt_secured;
  logic        rst_seen_ff;
  logic        nxt_rst_seen;

  // ---------------------------------------------------------------------------
  // per-vector pending flag and effective level
  // ---------------------------------------------------------------------------
  for (genvar v = 0; v < ivec_pkg::NUM_VEC; v++) begin : g_vec
    localparam logic [1:0] CLS = ivec_pkg::VEC_CLASS[2*v +: 2];
    localparam logic [1:0] FIX = ivec_pkg::VEC_FIXED_LVL[2*v +: 2];
    logic [1:0] cfg;
    logic       ack_hit;
    assign cfg     = level_cfg[2*v +: 2];
    assign ack_hit = fetch_ack && irq_valid_ff && (irq_vector_ff == 5'(v));

    always_comb begin
      if (CLS == ivec_pkg::CLS_NONE) begin
        nxt_pend[v] = 1'b0;
      end else if (req_set[v]) begin
        nxt_pend[v] = 1'b1;
      end else if (req_clr[v] || ack_hit) begin
        nxt_pend[v] = 1'b0;
      end else begin
        nxt_pend[v] = pend_ff[v];
      end
      case (CLS)
        ivec_pkg::CLS_FIXED: eff_lvl[2*v +: 2] = FIX;
        ivec_pkg::CLS_DBG:   eff_lvl[2*v +: 2] =
          (cfg < ivec_pkg::DBG_LVL_MIN) ? ivec_pkg::DBG_LVL_MIN : cfg;
        ivec_pkg::CLS_PERI:  eff_lvl[2*v +: 2] =
          (cfg > ivec_pkg::PERI_LVL_MAX) ? ivec_pkg::PERI_LVL_MAX : cfg;
        default:             eff_lvl[2*v +: 2] = 2'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // arbitration over the next pending set
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_valid  = 1'b0;
    nxt_vector = 5'h00;
    nxt_level  = 2'h0;
    // scan downward so an equal level at a lower number replaces the pick
    for (int i = ivec_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (nxt_pend[i] && (!nxt_valid || eff_lvl[2*i +: 2] >= nxt_level)) begin
        nxt_valid  = 1'b1;
        nxt_vector = 5'(i);
        nxt_level  = eff_lvl[2*i +: 2];
      end
    end
    // use the base that registers alongside, so a base write never pairs a stale address
    nxt_fetch_addr = nxt_vector_base +
                     {15'h0000, nxt_vector, 1'b0};
  end

  // ---------------------------------------------------------------------------
  // base, mode bits and reset entry
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_vector_base = vector_base_wr ? vector_base_in : vector_base_ff;
    // external map unusable: select sticks only if external boot allowed
    nxt_map_sel     = (boot_map_select_wr && ivec_pkg::EXT_BOOT_PIN) ?
                      boot_map_select_in : boot_map_select_ff;
    nxt_rst_seen    = 1'b1;
    // secured state is caught from the strap once after reset, later writes do nothing
    nxt_secured     = rst_seen_ff ? flash_secured_state_ff
                                  : flash_secure_strap;
    nxt_reset_entry = watchdog_reset_flag ? ivec_pkg::WDOG_ENTRY
                                          : ivec_pkg::BOOT_ENTRY;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_ff                <= 24'h000000;
      irq_valid_ff           <= 1'b0;
      irq_vector_ff          <= 5'h00;
      irq_level_ff           <= 2'h0;
      irq_fetch_addr_ff      <= ivec_pkg::VBASE_RST;
      vector_base_ff         <= ivec_pkg::VBASE_RST;
      reset_entry_ff         <= ivec_pkg::BOOT_ENTRY;
      boot_map_select_ff     <= ivec_pkg::EXT_BOOT_PIN;
      flash_secured_state_ff <= 1'b0;
      rst_seen_ff            <= 1'b0;
    end else if (clk_en) begin
      pend_ff                <= nxt_pend;
      irq_valid_ff           <= nxt_valid;
      irq_vector_ff          <= nxt_vector;
      irq_level_ff           <= nxt_level;
      irq_fetch_addr_ff      <= nxt_fetch_addr;
      vector_base_ff         <= nxt_vector_base;
      reset_entry_ff         <= nxt_reset_entry;
      boot_map_select_ff     <= nxt_map_sel;
      flash_secured_state_ff <= nxt_secured;
      rst_seen_ff            <= nxt_rst_seen;
    end
  end

  // ---------------------------------------------------------------------------
  // program space decode
  // ---------------------------------------------------------------------------
  prog_map_decode u_decode (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .fetch_addr      (fetch_addr),
    .region_ff       (region_ff),
    .inaccessible_ff (inaccessible_ff)
  );

endmodule : interrupt_priority_vector_map

//--- core/ivec_pkg.sv
package ivec_pkg;

  // ---------------------------------------------------------------------------
  // vector table geometry
  // ---------------------------------------------------------------------------
  localparam int          NUM_VEC     = 24;
  localparam int          VEC_W       = 5;
  localparam int          LVL_W       = 2;
  localparam int          ADDR_W      = 21;
  localparam int          VEC_SHIFT   = 1;
  localparam logic [20:0] VBASE_RST   = 21'h000000;

  // ---------------------------------------------------------------------------
  // per-vector level class
  // ---------------------------------------------------------------------------
  // class: 0 none, 1 fixed, 2 range 1-3, 3 range 0-2
  localparam logic [1:0] CLS_NONE  = 2'h0;
  localparam logic [1:0] CLS_FIXED = 2'h1;
  localparam logic [1:0] CLS_DBG   = 2'h2;
  localparam logic [1:0] CLS_PERI  = 2'h3;

  // vector 23 .. 0
  localparam logic [47:0] VEC_CLASS = {
    2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h1,
    2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0,
    2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
  localparam logic [47:0] VEC_FIXED_LVL = {
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0};
  localparam logic [1:0] DBG_LVL_MIN  = 2'h1;
  localparam logic [1:0] PERI_LVL_MAX = 2'h2;

  // ---------------------------------------------------------------------------
  // program map, internal boot
  // ---------------------------------------------------------------------------
  localparam logic [20:0] PFLASH_END   = 21'h007fff;
  localparam logic [20:0] RSV_LO_END   = 21'h00ffff;
  localparam logic [20:0] EXTRAM_END   = 21'h01ffff;
  localparam logic [20:0] BOOT_BEGIN   = 21'h020000;
  localparam logic [20:0] BOOT_END     = 21'h020fff;
  localparam logic [20:0] RSV_HI_END   = 21'h02f7ff;
  localparam logic [20:0] PRAM_END     = 21'h02ffff;
  localparam logic [20:0] BOOT_ENTRY   = 21'h020000;
  localparam logic [20:0] WDOG_ENTRY   = 21'h020002;
  localparam logic        EXT_BOOT_PIN = 1'b0;

  typedef enum logic [4:0] {
    REG_PFLASH = 5'b00001,
    REG_BOOT   = 5'b00010,
    REG_PRAM   = 5'b00100,
    REG_RSV    = 5'b01000,
    REG_EXT    = 5'b10000
  } region_type;

endpackage : ivec_pkg

//--- core/prog_map_decode.sv
`timescale 1ns/1ps
module prog_map_decode (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic [20:0]            fetch_addr,
  output ivec_pkg::region_type        region_ff,
  output logic                        inaccessible_ff
);

  ivec_pkg::region_type nxt_region;
  logic                 nxt_inaccessible;

  // ---------------------------------------------------------------------------
  // internal map decode
  // ---------------------------------------------------------------------------
  always_comb begin
    if (fetch_addr <= ivec_pkg::PFLASH_END) begin
      nxt_region = ivec_pkg::REG_PFLASH;
    end else if (fetch_addr <= ivec_pkg::RSV_LO_END) begin
      nxt_region = ivec_pkg::REG_RSV;
    end else if (fetch_addr <= ivec_pkg::EXTRAM_END) begin
      nxt_region = ivec_pkg::REG_EXT;
    end else if (fetch_addr <= ivec_pkg::BOOT_END) begin
      nxt_region = ivec_pkg::REG_BOOT;
    end else if (fetch_addr <= ivec_pkg::RSV_HI_END) begin
      nxt_region = ivec_pkg::REG_RSV;
    end else if (fetch_addr <= ivec_pkg::PRAM_END) begin
      nxt_region = ivec_pkg::REG_PRAM;
    end else begin
      nxt_region = ivec_pkg::REG_EXT;
    end
    nxt_inaccessible = (nxt_region == ivec_pkg::REG_EXT) ||
                       (nxt_region == ivec_pkg::REG_RSV);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      region_ff       <= ivec_pkg::REG_BOOT;
      inaccessible_ff <= 1'b0;
    end else if (clk_en) begin
      region_ff       <= nxt_region;
      inaccessible_ff <= nxt_inaccessible;
    end
  end

endmodule : prog_map_decode

//--- testbench/core_fetch_model.sv
`timescale 1ns/1ps
module core_fetch_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic irq_valid_ff,
  input  wire logic stall,
  output logic      fetch_ack
);
  logic ack_ff;
  logic nxt_ack;
  // one fetch per shown vector, none while the core is busy
  always_comb nxt_ack = irq_valid_ff && !stall && !ack_ff;
  always_ff @(posedge mclk) ack_ff <= rst_n ? nxt_ack : 1'b0;
  assign fetch_ack = ack_ff;
endmodule : core_fetch_model

//--- testbench/ivec_monitor.sv
`timescale 1ns/1ps
module ivec_monitor (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 clk_en,
  input wire logic [23:0]          req_set,
  input wire logic                 fetch_ack,
  input wire logic                 irq_valid_ff,
  input wire logic [4:0]           irq_vector_ff,
  input wire logic [1:0]           irq_level_ff,
  input wire logic [20:0]          irq_fetch_addr_ff,
  input wire logic [23:0]          pend_ff,
  input wire logic [20:0]          vector_base_ff,
  input wire logic                 boot_map_select_ff,
  input wire logic                 flash_secured_state_ff,
  input wire logic [4:0]           region_ff,
  input wire logic                 inaccessible_ff
);
  // ---------------------------------------------------------------
  // port checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  addr_form_a: assert property (irq_valid_ff |->
    irq_fetch_addr_ff == vector_base_ff + {15'h0, irq_vector_ff, 1'b0}) else $error("bad addr");
  valid_pend_a: assert property (irq_valid_ff == (pend_ff != 24'h0))
    else $error("valid without pending");
  win_pend_a: assert property (irq_valid_ff |-> pend_ff[irq_vector_ff])
    else $error("winner not pending");
  set_pend_a: assert property (clk_en && req_set[20] |=>
    pend_ff[20] && irq_valid_ff) else $error("set lost");
  rsv_slot_a: assert property ((pend_ff & 24'h083103) == 24'h0)
    else $error("reserved slot pending");
  fixed_lvl_a: assert property (irq_valid_ff && irq_vector_ff inside {[5'h2:5'h5]}
    |-> irq_level_ff == 2'h3) else $error("core level wrong");
  dbg_lvl_a: assert property (irq_valid_ff &&
    irq_vector_ff inside {5'h6, 5'h7, 5'h9, 5'ha, 5'hb} |-> irq_level_ff != 2'h0)
    else $error("debug level wrong");
  peri_lvl_a: assert property (irq_valid_ff && irq_vector_ff > 5'h10 |->
    irq_level_ff != 2'h3) else $error("peripheral level wrong");
  map_sel_a: assert property (!boot_map_select_ff)
    else $error("map select set");
  secure_hold_a: assert property ($past(rst_n) && $past(rst_n, 2) |->
    $stable(flash_secured_state_ff)) else $error("secured state moved");
  inacc_a: assert property (inaccessible_ff == (region_ff[4] || region_ff[3]))
    else $error("inaccessible wrong");
  fetch_c: cover property (fetch_ack && irq_valid_ff);
  lvl3_c: cover property (irq_valid_ff && irq_level_ff == 2'h3);
  ext_c: cover property (region_ff[4]);
endmodule : ivec_monitor

bind interrupt_priority_vector_map ivec_monitor u_mon (.mclk, .rst_n, .clk_en, .req_set,
  .fetch_ack, .irq_valid_ff, .irq_vector_ff, .irq_level_ff, .irq_fetch_addr_ff, .pend_ff,
  .vector_base_ff, .boot_map_select_ff, .flash_secured_state_ff, .region_ff, .inaccessible_ff);

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [23:0] req_set = '0;
  logic [23:0] req_clr = '0;
  logic [47:0] level_cfg = '0;
  logic [20:0] vector_base_in = '0;
  logic [20:0] fetch_addr = '0;
  logic        vector_base_wr = 1'b0;
  logic        bms_wr = 1'b0;
  logic        bms_in = 1'b0;
  logic        fss_wr = 1'b0;
  logic        fss_in = 1'b0;
  logic        wdog = 1'b0;
  logic        stall = 1'b0;
  logic        clk_en = 1'b1;
  logic        strap = 1'b1;
  logic        hung = 1'b0;
  logic [27:0] exp_v;
  logic        fetch_ack, irq_valid_ff, boot_map_select_ff, flash_secured_state_ff;
  logic        inaccessible_ff;
  logic [4:0]  irq_vector_ff;
  logic [1:0]  irq_level_ff;
  logic [20:0] irq_fetch_addr_ff, vector_base_ff, reset_entry_ff;
  ivec_pkg::region_type region_ff;
  logic [27:0] exp_q [$];
  logic [25:0] map_tab [8] = '{26'h00fffe1, 26'h0100008, 26'h0300010, 26'h0400002,
                               26'h041ffe2, 26'h0420008, 26'h05f0004, 26'h0600010};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          seed = 90;

  always #20 mclk = ~mclk;

  interrupt_priority_vector_map DUT (.mclk, .rst_n, .clk_en, .req_set, .req_clr,
    .level_cfg, .vector_base_wr, .vector_base_in, .fetch_ack, .boot_map_select_wr(bms_wr),
    .boot_map_select_in(bms_in), .flash_secured_state_wr(fss_wr),
    .flash_secured_state_in(fss_in), .flash_secure_strap(strap), .watchdog_reset_flag(wdog),
    .fetch_addr, .irq_valid_ff, .irq_vector_ff, .irq_level_ff, .irq_fetch_addr_ff,
    .pend_ff(), .vector_base_ff, .reset_entry_ff, .boot_map_select_ff,
    .flash_secured_state_ff, .region_ff, .inaccessible_ff);
  core_fetch_model u_core (.mclk, .rst_n, .irq_valid_ff, .stall, .fetch_ack);

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [27:0] e, logic [27:0] g);
    cmp_count++;
    if (e !== g) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  function automatic int lvl_of(int v, logic [47:0] c);
    logic [1:0] f;
    f = c[2*v +: 2];
    case (v)
      2, 3, 4, 5: return 3;
      14: return 2;
      15: return 1;
      16: return 0;
      6, 7, 9, 10, 11: return (f == 2'h0) ? 1 : int'(f);
      17, 18, 20, 21, 22, 23: return (f == 2'h3) ? 2 : int'(f);
      default: return -1;
    endcase
  endfunction : lvl_of

  always @(posedge mclk) begin
    if (rst_n && fetch_ack && irq_valid_ff === 1'b1) begin
      exp_v = exp_q.size() ? exp_q.pop_front() : '1;
      chk("level", 28'(exp_v[27:26]), 28'(irq_level_ff));
      chk("vector", 28'(exp_v[25:21]), 28'(irq_vector_ff));
      chk("addr", 28'(exp_v[20:0]), 28'(irq_fetch_addr_ff));
      chk("call_slot", 28'h1, 28'(irq_vector_ff > 5'h1));
    end
  end

  // requests pile up while the core stalls, then drain in priority order
  task automatic round();
    logic [23:0] s;
    logic [23:0] c;
    logic [20:0] b;
    s = 24'($random(seed));
    c = 24'($random(seed) & $random(seed));
    b = 21'($random(seed));
    @(posedge mclk);
    stall <= 1'b1;
    req_set <= s;
    level_cfg <= 48'({$random(seed), $random(seed)});
    vector_base_wr <= 1'b1;
    vector_base_in <= b;
    @(posedge mclk);
    req_set <= '0;
    req_clr <= c;
    vector_base_wr <= 1'b0;
    @(posedge mclk);
    req_clr <= '0;
    for (int lv = 3; lv >= 0; lv--) begin
      for (int v = 0; v < 24; v++) begin
        if (s[v] && !c[v] && lvl_of(v, level_cfg) == lv) begin
          exp_q.push_back({lv[1:0], v[4:0], b + 21'(2 * v)});
        end
      end
    end
    for (int k = 0; k < 300 && exp_q.size() != 0; k++) begin
      @(posedge mclk);
      stall <= 1'($random(seed));
      @(negedge mclk);
    end
    @(posedge mclk);
    stall <= 1'b0;
    chk("drain", 28'h0, 28'(exp_q.size()));
    hung = (exp_q.size() != 0);
    exp_q.delete();
  endtask : round

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("base", 28'h0, 28'(vector_base_ff));
    chk("entry", 28'h020000, 28'(reset_entry_ff));
    @(posedge mclk);
    {wdog, bms_wr, bms_in, fss_wr} <= 4'hf;
    strap <= 1'b0;
    @(posedge mclk);
    {bms_wr, fss_wr} <= 2'h0;
    @(negedge mclk);
    chk("wdog", 28'h020002, 28'(reset_entry_ff));
    chk("mapsel", 28'h0, 28'(boot_map_select_ff));
    chk("secured", 28'h1, 28'(flash_secured_state_ff));
    foreach (map_tab[i]) begin
      @(posedge mclk);
      fetch_addr <= map_tab[i][25:5];
      @(posedge mclk);
      @(negedge mclk);
      chk("region", 28'(map_tab[i][4:0]), 28'(region_ff));
      chk("inacc", 28'(map_tab[i][4:3] != 2'h0), 28'(inaccessible_ff));
    end
    // enable low freezes decode and entry; last map address was external
    @(posedge mclk);
    clk_en <= 1'b0;
    fetch_addr <= ivec_pkg::BOOT_BEGIN;
    wdog <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("frozen", 28'h10, 28'(region_ff));
    chk("frozen_entry", 28'h020002, 28'(reset_entry_ff));
    @(posedge mclk);
    clk_en <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("thawed", 28'h02, 28'(region_ff));
    chk("thawed_entry", 28'h020000, 28'(reset_entry_ff));
    for (int r = 0; r < 10 && !hung; r++) begin
      round();
    end
    test_done();
  end
endmodule : tb_top
